// file: core/acq_core.sv
// Analyzer clock selection, sampling qualifiers and trace tag counter
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Rising-edge mode samples on each rising edge of the line
// - Falling-edge mode samples on each falling edge of the line
// - Either-edge mode samples on both transitions of the line
// - Low qualifier allows sampling only while the line is low
// - High qualifier allows sampling only while the line is high
// - Background qualifier allows sampling only in background monitor code
// - Foreground qualifier is the default after reset or init
// - Any one of several enabled edges produces a sample
// - Several level qualifiers are ORed together
// - User and background qualifiers are ORed with all other qualifiers
// - Five clock lines; main clock and mode line may clock both analyzers
// - Speed grade selectable: slow, fast or very fast
// - Slow counts states or time, fast states only, very fast nothing
// - Counter counts its qualifier, is stored with each state, then cleared
// - Memory holds 1024 states untagged, 512 with tag counter active
// - Time mode measures time between consecutive stored states
// - Count qualifier defaults to time after reset or init
// - Arm is never accepted as count qualifier
// - When appended, emulation count qualifier governs both analyzers
module acq_core (
    input  wire logic        pclk,          // APB clock, 10 MHz
    input  wire logic        presetn,       // Async reset, active low
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB enable
    input  wire logic        pwrite,        // APB direction
    input  wire logic [7:0]  paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error
    input  wire logic [4:0]  clk_lines,     // Clock lines J..N, async
    input  wire logic [31:0] emu_data,      // Emulation trace state
    input  wire logic [31:0] ext_data,      // External trace state
    input  wire logic [1:0]  store_qual,    // Store qualifier per analyzer
    input  wire logic [1:0]  cnt_match,     // Count expression match
    output logic      [1:0]  sample_out,    // Qualified sample, registered
    output logic      [1:0]  tag_active     // Tag counter in use
);

    typedef struct packed {
        logic [4:0]             s1;
        logic [4:0]             s2;
        logic [4:0]             s3;
        logic [4:0]             stable;
        logic [1:0][4:0]        rise;
        logic [1:0][4:0]        fall;
        logic [1:0][4:0]        either;
        logic [1:0][4:0]        low;
        logic [1:0][4:0]        high;
        logic [1:0]             bgq;
        logic [1:0]             usr;
        logic [1:0][1:0]        speed;
        logic [1:0][1:0]        cq;
        logic [1:0]             run;
        logic                   append;
        logic [1:0][10:0]       nstored;
        logic [1:0][31:0]       tag;
        logic [1:0]             sample;
        logic [10:0]            maddr;
        logic [31:0]            rdata;
        logic                   slverr;
    } acq_state_t;

    acq_state_t             st;
    acq_state_t             nx;
    logic [31:0]            mem [acq_pkg::MEM_WORDS];
    logic [4:0]             agree;
    logic [4:0]             rise_e;
    logic [4:0]             fall_e;
    logic                   bg_line;
    logic [1:0]             edge_w;
    logic [1:0]             qual_w;
    logic [1:0]             sample_w;
    logic [1:0]             store_w;
    logic [1:0]             tag_on_w;
    logic [1:0]             full_w;
    logic [1:0]             start_w;
    logic [1:0][1:0]        mode_w;
    logic [1:0][10:0]       midx;
    logic [1:0][31:0]       tdata;
    logic                   wr;
    logic                   init_w;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] eff_mode(input logic [1:0] q,
                                            input logic [1:0] sp);
        if (sp == acq_pkg::SPD_SLOW) begin
            eff_mode = q;
        end else if (sp == acq_pkg::SPD_FAST && q == acq_pkg::CQ_STATE) begin
            eff_mode = q;
        end else begin
            eff_mode = acq_pkg::CQ_NONE;
        end
    endfunction : eff_mode

    function automatic logic [31:0] ck_word(input acq_state_t s, input int a);
        ck_word = 32'h0;
        ck_word[acq_pkg::K_RISE+:5]   = s.rise[a];
        ck_word[acq_pkg::K_FALL+:5]   = s.fall[a];
        ck_word[acq_pkg::K_EITHER+:5] = s.either[a];
        ck_word[acq_pkg::K_LOW+:5]    = s.low[a];
        ck_word[acq_pkg::K_HIGH+:5]   = s.high[a];
        ck_word[acq_pkg::K_BG]        = s.bgq[a];
        ck_word[acq_pkg::K_USER]      = s.usr[a];
        ck_word[acq_pkg::K_SPEED+:2]  = s.speed[a];
    endfunction : ck_word

    assign wr     = psel & penable & pwrite;
    assign init_w = wr && paddr == acq_pkg::A_CTRL && pwdata[acq_pkg::C_INIT];
    assign tdata  = {ext_data, emu_data};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nx = st;
        // A line counts as changed once the second and third stage agree
        nx.s1 = clk_lines;
        nx.s2 = st.s1;
        nx.s3 = st.s2;
        agree  = ~(st.s2 ^ st.s3);
        rise_e = agree & st.s2 & ~st.stable;
        fall_e = agree & ~st.s2 & st.stable;
        nx.stable = (agree & st.s2) | (~agree & st.stable);
        // Mode line high means the processor runs the background monitor
        bg_line = st.stable[acq_pkg::LINE_N];
        for (int a = 0; a < 2; a++) begin
            start_w[a] = 1'b0;
            edge_w[a] = |(st.rise[a] & rise_e)
                      | |(st.fall[a] & fall_e)
                      | |(st.either[a] & (rise_e | fall_e));
            // With nothing enabled the qualifier stays open
            qual_w[a] = (st.low[a] == 5'h00 && st.high[a] == 5'h00
                         && !st.bgq[a] && !st.usr[a])
                      | |(st.low[a] & ~st.stable)
                      | |(st.high[a] & st.stable)
                      | (st.bgq[a] & bg_line)
                      | (st.usr[a] & ~bg_line);
            sample_w[a] = edge_w[a] & qual_w[a];
            nx.sample[a] = sample_w[a];
            if (a == 1 && st.append) begin
                mode_w[a] = eff_mode(st.cq[0], st.speed[0]);
            end else begin
                mode_w[a] = eff_mode(st.cq[a], st.speed[a]);
            end
            tag_on_w[a] = mode_w[a] != acq_pkg::CQ_NONE;
            full_w[a] = st.nstored[a] >= (tag_on_w[a] ? acq_pkg::N_TAG
                                                      : acq_pkg::N_PLAIN);
            store_w[a] = ((a == 1 && st.append) ? st.run[0] : st.run[a])
                       & sample_w[a] & store_qual[a] & ~full_w[a];
            // Tag words sit right after their state, so depth halves
            midx[a] = {1'(a), tag_on_w[a] ? {st.nstored[a][8:0], 1'b0}
                                          : st.nstored[a][9:0]};
            // Counter restarts from this cycle's own event, so none is lost
            if (store_w[a]) begin
                nx.tag[a] = {31'h0, mode_w[a] == acq_pkg::CQ_TIME
                            || (mode_w[a] == acq_pkg::CQ_STATE && sample_w[a]
                                && cnt_match[a])};
                nx.nstored[a] = st.nstored[a] + 11'h001;
            end else if (mode_w[a] == acq_pkg::CQ_TIME) begin
                nx.tag[a] = st.tag[a] + 32'h1;
            end else if (mode_w[a] == acq_pkg::CQ_STATE
                         && sample_w[a] && cnt_match[a]) begin
                nx.tag[a] = st.tag[a] + 32'h1;
            end
        end
        // Register writes
        if (wr) begin
            if (paddr == acq_pkg::A_CTRL) begin
                nx.append = pwdata[acq_pkg::C_APPEND];
                for (int a = 0; a < 2; a++) begin
                    nx.run[a] = pwdata[acq_pkg::C_RUN+a];
                    start_w[a] = nx.run[a] & ~st.run[a];
                end
                // An appended external trace starts with the emulation one
                if (nx.append) begin
                    start_w[1] = start_w[0];
                end
                for (int a = 0; a < 2; a++) begin
                    if (start_w[a]) begin
                        nx.nstored[a] = 11'h000;
                        nx.tag[a] = 32'h0;
                    end
                end
            end else if (paddr == acq_pkg::A_EMUCK || paddr == acq_pkg::A_EXTCK) begin
                for (int a = 0; a < 2; a++) begin
                    if (paddr == (a == 0 ? acq_pkg::A_EMUCK : acq_pkg::A_EXTCK)) begin
                        nx.rise[a]   = pwdata[acq_pkg::K_RISE+:5];
                        nx.fall[a]   = pwdata[acq_pkg::K_FALL+:5];
                        nx.either[a] = pwdata[acq_pkg::K_EITHER+:5];
                        nx.low[a]    = pwdata[acq_pkg::K_LOW+:5];
                        nx.high[a]   = pwdata[acq_pkg::K_HIGH+:5];
                        nx.bgq[a]    = pwdata[acq_pkg::K_BG];
                        nx.usr[a]    = pwdata[acq_pkg::K_USER];
                        // Unused code 3 falls back to very fast, the safe grade
                        nx.speed[a]  = pwdata[acq_pkg::K_SPEED+:2] == 2'h3
                                     ? acq_pkg::SPD_VERY_FAST
                                     : pwdata[acq_pkg::K_SPEED+:2];
                    end
                end
            end else if (paddr == acq_pkg::A_CNTQ) begin
                for (int a = 0; a < 2; a++) begin
                    if (pwdata[a*acq_pkg::Q_STRIDE+:2] != acq_pkg::CQ_ARM) begin
                        nx.cq[a] = pwdata[a*acq_pkg::Q_STRIDE+:2];
                    end
                end
            end else if (paddr == acq_pkg::A_MADDR) begin
                nx.maddr = pwdata[10:0];
            end
        end
        // Init restores the defaults and stops both traces
        if (init_w) begin
            nx.append = 1'b0;
            for (int a = 0; a < 2; a++) begin
                nx.rise[a]    = acq_pkg::RST_RISE;
                nx.fall[a]    = 5'h00;
                nx.either[a]  = 5'h00;
                nx.low[a]     = 5'h00;
                nx.high[a]    = 5'h00;
                nx.bgq[a]     = 1'b0;
                nx.usr[a]     = acq_pkg::RST_USER;
                nx.speed[a]   = acq_pkg::RST_SPEED;
                nx.cq[a]      = acq_pkg::RST_CQ;
                nx.run[a]     = 1'b0;
                nx.nstored[a] = 11'h000;
                nx.tag[a]     = 32'h0;
            end
        end
        // Read data is captured in the setup cycle
        if (psel && !penable) begin
            nx.slverr = 1'b0;
            nx.rdata = 32'h0;
            if (paddr == acq_pkg::A_CTRL) begin
                nx.rdata[acq_pkg::C_RUN+:2] = st.run;
                nx.rdata[acq_pkg::C_APPEND] = st.append;
            end else if (paddr == acq_pkg::A_EMUCK) begin
                nx.rdata = ck_word(st, 0);
            end else if (paddr == acq_pkg::A_EXTCK) begin
                nx.rdata = ck_word(st, 1);
            end else if (paddr == acq_pkg::A_CNTQ) begin
                nx.rdata[3:0] = st.cq;
            end else if (paddr == acq_pkg::A_STAT) begin
                for (int a = 0; a < 2; a++) begin
                    nx.rdata[a*acq_pkg::S_STRIDE+:11] = st.nstored[a];
                    nx.rdata[a*acq_pkg::S_STRIDE+acq_pkg::S_FULL] = full_w[a];
                    nx.rdata[a*acq_pkg::S_STRIDE+acq_pkg::S_TAG] = tag_on_w[a];
                end
            end else if (paddr == acq_pkg::A_MADDR) begin
                nx.rdata[10:0] = st.maddr;
            end else if (paddr == acq_pkg::A_MDATA) begin
                nx.rdata = mem[st.maddr];
            end else begin
                nx.slverr = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            for (int a = 0; a < 2; a++) begin
                st.rise[a]  <= acq_pkg::RST_RISE;
                st.usr[a]   <= acq_pkg::RST_USER;
                st.speed[a] <= acq_pkg::RST_SPEED;
                st.cq[a]    <= acq_pkg::RST_CQ;
            end
        end else begin
            st <= nx;
        end
    end

    // Trace memory: state word, then its tag word when tagging
    always_ff @(posedge pclk) begin
        for (int a = 0; a < 2; a++) begin
            if (store_w[a]) begin
                mem[midx[a]] <= tdata[a];
                if (tag_on_w[a]) begin
                    mem[midx[a] + 11'h001] <= st.tag[a];
                end
            end
        end
    end

    assign prdata     = st.rdata;
    assign pready     = 1'b1;
    assign pslverr    = psel & penable & st.slverr;
    assign sample_out = st.sample;
    assign tag_active = tag_on_w;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    rise_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        rise_e[acq_pkg::LINE_L] && st.rise[0][acq_pkg::LINE_L] && qual_w[0]
        |=> st.sample[0])
        else $error("rising edge missed");
    fall_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        fall_e[acq_pkg::LINE_L] && st.fall[0][acq_pkg::LINE_L] && qual_w[0]
        |=> st.sample[0])
        else $error("falling edge missed");
    either_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(st.stable[acq_pkg::LINE_J]) && $past(st.either[1][acq_pkg::LINE_J])
        && $past(qual_w[1]) |-> st.sample[1])
        else $error("either edge missed");
    low_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.sample[0] && $past(st.low[0] == 5'h01 && st.high[0] == 5'h00
        && !st.bgq[0] && !st.usr[0]) |-> !$past(st.stable[acq_pkg::LINE_J]))
        else $error("low qualifier leaked");
    high_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.sample[0] && $past(st.high[0] == 5'h01 && st.low[0] == 5'h00
        && !st.bgq[0] && !st.usr[0]) |-> $past(st.stable[acq_pkg::LINE_J]))
        else $error("high qualifier leaked");
    bg_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.sample[0] && $past(st.bgq[0] && !st.usr[0] && st.low[0] == 5'h00
        && st.high[0] == 5'h00) |-> $past(bg_line))
        else $error("background qualifier leaked");
    init_user_a: assert property (@(posedge pclk) disable iff (!presetn)
        init_w |=> st.usr == 2'b11 && st.bgq == 2'b00)
        else $error("user qualifier not default");
    init_time_a: assert property (@(posedge pclk) disable iff (!presetn)
        init_w |=> st.cq[0] == acq_pkg::CQ_TIME && st.cq[1] == acq_pkg::CQ_TIME)
        else $error("count default not time");
    speed_limit_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.speed[0] == acq_pkg::SPD_VERY_FAST
        || (st.speed[0] == acq_pkg::SPD_FAST && st.cq[0] == acq_pkg::CQ_TIME)
        |-> !tag_on_w[0])
        else $error("tag counter allowed at this speed");
    tag_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        store_w[0] && !init_w |=> st.tag[0] <= 32'h1)
        else $error("tag not cleared on store");
    // The edge that ends reset still sees the held counter, so it is skipped
    time_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        presetn && mode_w[0] == acq_pkg::CQ_TIME && !store_w[0] && !init_w && !start_w[0]
        |=> st.tag[0] == $past(st.tag[0]) + 32'h1)
        else $error("time count stalled");
    depth_cap_a: assert property (@(posedge pclk) disable iff (!presetn)
        tag_on_w[0] |-> st.nstored[0] <= acq_pkg::N_TAG)
        else $error("tagged depth exceeded");
    no_arm_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.cq[0] != acq_pkg::CQ_ARM && st.cq[1] != acq_pkg::CQ_ARM)
        else $error("arm taken as count qualifier");
    append_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.append |-> tag_on_w[1] == tag_on_w[0])
        else $error("appended count qualifier differs");
    store_count_a: assert property (@(posedge pclk) disable iff (!presetn)
        store_w[0] && !init_w && !start_w[0]
        |=> st.nstored[0] == $past(st.nstored[0]) + 11'h001)
        else $error("stored state not counted");
    speed_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.speed[0] != 2'h3 && st.speed[1] != 2'h3)
        else $error("undefined speed grade held");
    plain_depth_a: assert property (@(posedge pclk) disable iff (!presetn)
        !tag_on_w[0] |-> st.nstored[0] <= acq_pkg::N_PLAIN)
        else $error("untagged depth exceeded");
    sample_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.sample[0] |-> $past(edge_w[0] && qual_w[0]))
        else $error("sample without qualified edge");
    ext_speed_a: assert property (@(posedge pclk) disable iff (!presetn)
        st.speed[1] == acq_pkg::SPD_VERY_FAST && !st.append |-> !tag_on_w[1])
        else $error("external tag counter allowed at this speed");

endmodule : acq_core
`default_nettype wire

// file: core/acq_pkg.sv
// Constants for the analyzer clock qualifier and tag counter block
package acq_pkg;

    // ------------------------------------------------------------
    // Clock lines
    // ------------------------------------------------------------
    localparam int          LINES    = 5;
    localparam int          LINE_J   = 0;
    localparam int          LINE_L   = 2;
    localparam int          LINE_N   = 4;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0]  A_CTRL   = 8'h00;
    localparam logic [7:0]  A_EMUCK  = 8'h04;
    localparam logic [7:0]  A_EXTCK  = 8'h08;
    localparam logic [7:0]  A_CNTQ   = 8'h0c;
    localparam logic [7:0]  A_STAT   = 8'h10;
    localparam logic [7:0]  A_MADDR  = 8'h14;
    localparam logic [7:0]  A_MDATA  = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          C_INIT   = 0;
    localparam int          C_RUN    = 1;
    localparam int          C_APPEND = 3;
    localparam int          K_RISE   = 0;
    localparam int          K_FALL   = 5;
    localparam int          K_EITHER = 10;
    localparam int          K_LOW    = 15;
    localparam int          K_HIGH   = 20;
    localparam int          K_BG     = 25;
    localparam int          K_USER   = 26;
    localparam int          K_SPEED  = 27;
    localparam int          Q_STRIDE = 2;
    localparam int          S_STRIDE = 16;
    localparam int          S_FULL   = 11;
    localparam int          S_TAG    = 12;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  SPD_SLOW      = 2'h0;
    localparam logic [1:0]  SPD_FAST      = 2'h1;
    localparam logic [1:0]  SPD_VERY_FAST = 2'h2;
    localparam int          SLOW_MAX_MHZ  = 16;
    localparam int          FAST_MAX_MHZ  = 20;
    localparam int          VFAST_MAX_MHZ = 25;
    localparam logic [1:0]  CQ_NONE  = 2'h0;
    localparam logic [1:0]  CQ_TIME  = 2'h1;
    localparam logic [1:0]  CQ_STATE = 2'h2;
    localparam logic [1:0]  CQ_ARM   = 2'h3;

    // ------------------------------------------------------------
    // Values after reset or init, depths
    // ------------------------------------------------------------
    localparam logic [4:0]  RST_RISE  = 5'h04;
    localparam logic        RST_USER  = 1'b1;
    localparam logic [1:0]  RST_SPEED = 2'h0;
    localparam logic [1:0]  RST_CQ    = 2'h1;
    localparam logic [10:0] N_PLAIN   = 11'h400;
    localparam logic [10:0] N_TAG     = 11'h200;
    localparam int          MEM_WORDS = 2048;

endpackage : acq_pkg

// file: verification/acq_target.sv
// Far-side model: target clock lines and probe clocks
`timescale 1ns/1ps
`default_nettype none
module acq_target (
    input  wire logic       pclk,       // Bench clock
    input  wire logic [4:0] lines_req,  // Requested line levels
    output logic      [4:0] clk_lines   // Lines toward the analyzer
);
    // Lines move just after an edge, as target logic would
    always_ff @(posedge pclk) begin
        clk_lines <= lines_req;
    end
endmodule : acq_target
`default_nettype wire

// file: verification/analyzer_clock_qualify_tag_count_bench.sv
// Self-checking bench for the analyzer clock qualifier and tag counter
`timescale 1ns/1ps
`default_nettype none
module analyzer_clock_qualify_tag_count_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, emu_dat;
    logic [4:0]  lines_req, clk_lines;
    logic [1:0]  sample_out, tag_active;
    int          miscompares, checked, cycles, pulses, pulses_x;

    acq_target u_tgt (.pclk(pclk), .lines_req(lines_req), .clk_lines(clk_lines));
    acq_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .clk_lines(clk_lines),
        .emu_data(emu_dat), .ext_data(32'h0), .store_qual(2'h3), .cnt_match(2'h0),
        .sample_out(sample_out), .tag_active(tag_active));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Ceiling well above the roughly 710 cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (sample_out[0] === 1'b1) pulses++;
        if (sample_out[1] === 1'b1) pulses_x++;
        if (cycles > 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Only the cycle ceiling ends a wait for ready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Four toggles of the main clock line give two rises and two falls
    task automatic edges(input logic [31:0] cfg, input logic [4:0] hold, input int exp);
        apb(1'b1, acq_pkg::A_EMUCK, cfg);
        lines_req <= hold;
        repeat (8) @(posedge pclk);
        pulses = 0;
        repeat (4) begin
            lines_req <= lines_req ^ 5'h04;
            repeat (8) @(posedge pclk);
        end
        chk("sample count", exp, 32'(pulses));
    endtask : edges

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk("register", e, rd);
    endtask : reg_chk

    task automatic tag_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        apb(1'b1, a, d);
        @(posedge pclk);
        chk("tag_active", 32'(e), 32'(tag_active));
    endtask : tag_chk

    // Four toggles of probe line J on the external analyzer
    task automatic ext_edges(input logic [31:0] cfg, input int exp);
        apb(1'b1, acq_pkg::A_EXTCK, cfg);
        repeat (8) @(posedge pclk);
        pulses_x = 0;
        repeat (4) begin
            lines_req <= lines_req ^ 5'h01;
            repeat (8) @(posedge pclk);
        end
        chk("ext sample count", exp, 32'(pulses_x));
    endtask : ext_edges

    task automatic mem_chk(input logic [10:0] i, input logic [31:0] e);
        apb(1'b1, acq_pkg::A_MADDR, {21'h0, i});
        reg_chk(acq_pkg::A_MDATA, e);
    endtask : mem_chk

    // Two rising L edges 16 cycles apart are stored, each followed by its tag
    task automatic store_run();
        apb(1'b1, acq_pkg::A_CTRL, 32'h00000002);
        repeat (4) begin
            emu_dat   <= emu_dat + 32'h00000011;
            lines_req <= lines_req ^ 5'h04;
            repeat (8) @(posedge pclk);
        end
        reg_chk(acq_pkg::A_STAT, 32'h10001002);
        mem_chk(11'h000, 32'h00000011);
        mem_chk(11'h002, 32'h00000033);
        mem_chk(11'h003, 32'h00000010);
    endtask : store_run

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lines_req = 5'h00;
        emu_dat = 32'h0;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        pulses = 0;
        pulses_x = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        reg_chk(acq_pkg::A_EMUCK, 32'h04000004);
        reg_chk(acq_pkg::A_CNTQ, 32'h00000005);
        apb(1'b1, acq_pkg::A_CNTQ, 32'h0000000f);
        reg_chk(acq_pkg::A_CNTQ, 32'h00000005);
        apb(1'b0, 8'h1c, 32'h0);
        chk("pslverr", 32'h1, 32'(err));
        edges(32'h04000004, 5'h00, 2);
        edges(32'h04000080, 5'h00, 2);
        edges(32'h04001000, 5'h00, 4);
        edges(32'h04000084, 5'h00, 4);
        edges(32'h00008004, 5'h01, 0);
        edges(32'h00008004, 5'h00, 2);
        edges(32'h00100004, 5'h00, 0);
        edges(32'h00100004, 5'h01, 2);
        edges(32'h04000004, 5'h10, 0);
        edges(32'h02000004, 5'h10, 2);
        edges(32'h02000004, 5'h00, 0);
        edges(32'h00108004, 5'h01, 2);
        edges(32'h04008004, 5'h01, 2);
        ext_edges(32'h04000400, 4);
        tag_chk(acq_pkg::A_EMUCK, 32'h14000004, 2'h2);
        tag_chk(acq_pkg::A_EMUCK, 32'h0c000004, 2'h2);
        tag_chk(acq_pkg::A_CNTQ, 32'h00000006, 2'h3);
        tag_chk(acq_pkg::A_CNTQ, 32'h00000004, 2'h2);
        tag_chk(acq_pkg::A_CTRL, 32'h00000008, 2'h0);
        tag_chk(acq_pkg::A_CTRL, 32'h00000001, 2'h3);
        store_run();
        reg_chk(acq_pkg::A_CNTQ, 32'h00000005);
        end_sim();
    end
endmodule : analyzer_clock_qualify_tag_count_bench
`default_nettype wire
